// File: logic/mac_packet_buffering.sv
// mac packet buffering: host fifos, mac working buffers, store-and-forward, flow control

// Behaviour
// R01: mac layer keeps own 2 KB transmit and 128 byte receive working buffers.
// R02: host has no port reaching the mac working buffers.
// R03: frames already in mac working buffers ignore any host control.
// R04: received words reach the host only after landing in host receive fifo.
// R05: transmit collects a whole frame before any word goes to the line.
// R06: receive fifo too full automatically requests pause frames.
// R07: alternatively, receive fifo too full asserts collision back-pressure.
// R08: pause is sent on fill level and on explicit host request.
// R09: host transmit and receive fifos sized 2 to 14 KB from shared store.
// R10: separate transmit and receive paths carry data plus per-packet status words.
// R11: frame with no room in host receive fifo is discarded, never overwrites.
module mac_packet_buffering import mac_buf_pkg::*; (
  // clock and reset
  input  wire logic      core_clk,
  input  wire logic      rst,
  // host transmit fifo write side
  input  wire logic      htx_valid,
  input  wire beat_t     htx_beat,
  output logic           htx_ready,
  // host receive fifo read side
  output logic           hrx_valid,
  output beat_t          hrx_beat,
  input  wire logic      hrx_ready,
  // per-packet status words
  output logic           tx_stat_valid,
  output pkt_stat_t      tx_stat,
  output logic           rx_stat_valid,
  output pkt_stat_t      rx_stat,
  // line transmit to mac
  output logic           ltx_valid,
  output beat_t          ltx_beat,
  input  wire logic      ltx_ready,
  // line receive from mac, cannot be stalled
  input  wire logic      lrx_valid,
  input  wire beat_t     lrx_beat,
  input  wire logic      lrx_err,
  // fifo sizing
  input  wire logic      cfg_load,
  input  wire logic [3:0] cfg_tx_kb,
  output logic [3:0]     fifo_tx_kb,
  // flow control
  input  wire logic      fc_auto_en,
  input  wire logic      fc_bp_mode,
  input  wire logic      pause_req,
  output logic           pause_send,
  output logic           jam_assert
);

  ////////////////////////////////////////////////////////////////////////////
  // declarations

  beat_t             store_mem [STORE_WORDS];
  beat_t             tx_buf    [TX_BUF_WORDS];
  rx_beat_t          rx_buf    [RX_BUF_WORDS];

  logic [3:0]        tx_kb_ff;
  logic [CW-1:0]     tx_sz;
  logic [CW-1:0]     rx_sz;

  logic [ST_AW-1:0]  htx_wp_ff;
  logic [ST_AW-1:0]  htx_rp_ff;
  logic [CW-1:0]     htx_cnt_ff;
  logic [CW-1:0]     nxt_htx_cnt;
  logic [CW-1:0]     htx_pkts_ff;
  logic              htx_ready_ff;
  logic              htx_fire;

  tx_state_t         tx_state_ff;
  logic [TXB_AW:0]   tb_wp_ff;
  logic [TXB_AW:0]   tb_rp_ff;
  logic [TXB_AW:0]   tb_len_ff;
  logic              tx_over_ff;
  logic              tx_pop;
  logic              tx_fit;
  beat_t             tx_rd;
  logic              ltx_valid_ff;
  beat_t             ltx_beat_ff;
  logic              tx_stat_valid_ff;
  pkt_stat_t         tx_stat_ff;

  logic [RXB_AW-1:0] rb_wp_ff;
  logic [RXB_AW-1:0] rb_rp_ff;
  logic [RXB_AW:0]   rb_cnt_ff;
  logic              rb_full;
  logic              rb_push;
  logic              rb_mark;
  logic              rb_pop;
  logic              lrx_ovf_ff;
  logic              lrx_end_pend_ff;
  rx_beat_t          rx_in;

  rx_state_t         rx_state_ff;
  logic [ST_AW-1:0]  rx_wp_ff;
  logic [ST_AW-1:0]  rx_cwp_ff;
  logic [CW-1:0]     rx_flen_ff;
  logic [CW-1:0]     rx_used;
  logic              rx_room;
  logic              rx_st_we;
  logic              rx_commit;
  logic              rx_good;
  logic              rx_stat_valid_ff;
  pkt_stat_t         rx_stat_ff;

  logic [ST_AW-1:0]  hrx_rp_ff;
  logic [CW-1:0]     hrx_cnt_ff;
  logic              hrx_load;
  logic              hrx_valid_ff;
  beat_t             hrx_beat_ff;

  logic              fc_full_ff;
  logic [CW-1:0]     rx_free;
  logic              pause_send_ff;
  logic              jam_ff;
  logic              cfg_idle;

  function automatic logic [ST_AW-1:0] ptr_inc(input logic [ST_AW-1:0] p,
                                               input logic [CW-1:0]    sz);
    ptr_inc = ((CW'(p) + CW'(1)) == sz) ? '0 : p + ST_AW'(1);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // fifo sizing

  assign tx_sz = CW'(tx_kb_ff) << KB_SHIFT;
  assign rx_sz = STORE_SZ - tx_sz;

  // resizing moves the region split, so only allowed with everything drained
  assign cfg_idle = (htx_cnt_ff == '0) && (hrx_cnt_ff == '0) && !hrx_valid_ff &&
                    (tx_state_ff == TX_IDLE) && (rx_flen_ff == '0) && !htx_valid &&
                    (rb_cnt_ff == '0);

  always_ff @(posedge core_clk) begin
    if (rst) begin
      tx_kb_ff <= TX_KB_RST;
    end else if (cfg_load && cfg_idle) begin
      if (cfg_tx_kb < FIFO_KB_MIN) begin
        tx_kb_ff <= FIFO_KB_MIN; // R09
      end else if (cfg_tx_kb > FIFO_KB_MAX) begin
        tx_kb_ff <= FIFO_KB_MAX; // R09
      end else begin
        tx_kb_ff <= cfg_tx_kb; // R09
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // shared store: transmit region at the bottom, receive region above it

  always_ff @(posedge core_clk) begin
    if (htx_fire) begin
      store_mem[htx_wp_ff] <= htx_beat;
    end
    if (rx_st_we) begin
      store_mem[tx_sz[ST_AW-1:0] + rx_wp_ff] <= rx_in.b; // R04
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // host transmit fifo

  assign htx_fire    = htx_valid && htx_ready_ff;
  assign nxt_htx_cnt = htx_cnt_ff + CW'(htx_fire) - CW'(tx_pop);

  always_ff @(posedge core_clk) begin
    if (rst) begin
      htx_wp_ff    <= '0;
      htx_rp_ff    <= '0;
      htx_cnt_ff   <= '0;
      htx_pkts_ff  <= '0;
      htx_ready_ff <= 1'b0;
    end else begin
      if (htx_fire) begin
        htx_wp_ff <= ptr_inc(htx_wp_ff, tx_sz);
      end
      if (tx_pop) begin
        htx_rp_ff <= ptr_inc(htx_rp_ff, tx_sz);
      end
      htx_cnt_ff   <= nxt_htx_cnt;
      htx_pkts_ff  <= htx_pkts_ff + CW'(htx_fire && htx_beat.last)
                      - CW'(tx_pop && tx_rd.last);
      // registered ready keeps one spare slot for the write in flight
      htx_ready_ff <= (nxt_htx_cnt + HTX_READY_MARGIN) <= tx_sz;
      // a new split needs the rings to restart inside their new regions
      if (cfg_load && cfg_idle) begin
        htx_wp_ff <= '0;
        htx_rp_ff <= '0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // transmit mover and store-and-forward sender

  assign tx_pop = (tx_state_ff == TX_FILL);
  assign tx_rd  = store_mem[htx_rp_ff];
  assign tx_fit = (tb_wp_ff < (TXB_AW + 1)'(TX_BUF_WORDS));

  always_ff @(posedge core_clk) begin
    if (rst) begin
      tx_state_ff      <= TX_IDLE;
      tb_wp_ff         <= '0;
      tb_rp_ff         <= '0;
      tb_len_ff        <= '0;
      tx_over_ff       <= 1'b0;
      ltx_valid_ff     <= 1'b0;
      ltx_beat_ff      <= '0;
      tx_stat_valid_ff <= 1'b0;
      tx_stat_ff       <= '0;
    end else begin
      tx_stat_valid_ff <= 1'b0;
      case (tx_state_ff)
        TX_IDLE: begin
          // only whole frames leave the host fifo
          if (htx_pkts_ff != '0) begin
            tx_state_ff <= TX_FILL; // R05
            tb_wp_ff    <= '0;
            tx_over_ff  <= 1'b0;
          end
        end
        TX_FILL: begin
          if (tx_fit) begin
            tx_buf[tb_wp_ff[TXB_AW-1:0]] <= tx_rd; // R01 R02
            tb_wp_ff <= tb_wp_ff + (TXB_AW + 1)'(1);
          end else begin
            tx_over_ff <= 1'b1;
          end
          if (tx_rd.last) begin
            tb_rp_ff <= '0;
            if (!tx_fit || tx_over_ff) begin
              // oversize frame cannot be held whole, so it is never sent
              tx_stat_valid_ff <= 1'b1; // R10
              tx_stat_ff       <= '{words: 16'(tb_wp_ff), rsvd: '0, drop: 1'b1, err: 1'b1};
              tx_state_ff      <= TX_IDLE;
            end else begin
              tb_len_ff   <= tb_wp_ff + (TXB_AW + 1)'(1);
              tx_state_ff <= TX_SEND; // R05
            end
          end
        end
        TX_SEND: begin
          // no host input reaches this path once the frame is buffered
          if (!ltx_valid_ff || ltx_ready) begin // R03
            if (tb_rp_ff != tb_len_ff) begin
              ltx_valid_ff <= 1'b1;
              ltx_beat_ff  <= tx_buf[tb_rp_ff[TXB_AW-1:0]];
              tb_rp_ff     <= tb_rp_ff + (TXB_AW + 1)'(1);
            end else begin
              ltx_valid_ff     <= 1'b0;
              tx_stat_valid_ff <= 1'b1; // R10
              tx_stat_ff       <= '{words: 16'(tb_len_ff), rsvd: '0, drop: 1'b0, err: 1'b0};
              tx_state_ff      <= TX_IDLE;
            end
          end
        end
        default: begin
          tx_state_ff <= TX_IDLE;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // mac receive working buffer, fed by the line at line rate

  assign rb_full = (rb_cnt_ff == (RXB_AW + 1)'(RX_BUF_WORDS));
  assign rb_push = lrx_valid && !lrx_ovf_ff && !rb_full;
  assign rb_mark = lrx_end_pend_ff && !rb_full;
  assign rb_pop  = (rb_cnt_ff != '0);
  assign rx_in   = rx_buf[rb_rp_ff];

  always_ff @(posedge core_clk) begin
    if (rst) begin
      rb_wp_ff        <= '0;
      rb_rp_ff        <= '0;
      rb_cnt_ff       <= '0;
      lrx_ovf_ff      <= 1'b0;
      lrx_end_pend_ff <= 1'b0;
    end else begin
      if (rb_push) begin
        rx_buf[rb_wp_ff] <= '{err: lrx_err, b: lrx_beat}; // R01
      end else if (rb_mark) begin
        // closing marker makes the mover drop the overrun frame
        rx_buf[rb_wp_ff] <= '{err: 1'b1, b: '{data: '0, last: 1'b1}};
      end
      if (rb_push || rb_mark) begin
        rb_wp_ff <= rb_wp_ff + RXB_AW'(1);
      end
      if (rb_pop) begin
        rb_rp_ff <= rb_rp_ff + RXB_AW'(1);
      end
      rb_cnt_ff <= rb_cnt_ff + (RXB_AW + 1)'(rb_push || rb_mark) - (RXB_AW + 1)'(rb_pop);
      if (rb_mark) begin
        lrx_ovf_ff      <= 1'b0;
        lrx_end_pend_ff <= 1'b0;
      end else if (lrx_valid && (lrx_ovf_ff || rb_full)) begin
        lrx_ovf_ff <= 1'b1;
        if (lrx_beat.last) begin
          lrx_end_pend_ff <= 1'b1;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // receive mover into the host receive fifo

  always_comb begin
    rx_used   = hrx_cnt_ff + rx_flen_ff;
    rx_room   = rx_used < rx_sz;
    rx_st_we  = rb_pop && (rx_state_ff == RX_MOVE) && rx_room;
    rx_good   = rx_st_we && !rx_in.err;
    rx_commit = rb_pop && rx_in.b.last && rx_good;
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      rx_state_ff      <= RX_MOVE;
      rx_wp_ff         <= '0;
      rx_cwp_ff        <= '0;
      rx_flen_ff       <= '0;
      rx_stat_valid_ff <= 1'b0;
      rx_stat_ff       <= '0;
    end else begin
      rx_stat_valid_ff <= 1'b0;
      if (rx_st_we) begin
        rx_wp_ff   <= ptr_inc(rx_wp_ff, rx_sz);
        rx_flen_ff <= rx_flen_ff + CW'(1);
      end else if (rb_pop) begin
        rx_state_ff <= RX_DROP; // R11
      end
      if (rb_pop && rx_in.b.last) begin
        rx_flen_ff       <= '0;
        rx_state_ff      <= RX_MOVE;
        rx_stat_valid_ff <= 1'b1; // R10
        if (rx_commit) begin
          rx_cwp_ff  <= ptr_inc(rx_wp_ff, rx_sz);
          rx_stat_ff <= '{words: 16'(rx_flen_ff + CW'(1)), rsvd: '0, drop: 1'b0, err: 1'b0};
        end else begin
          // rewind over the partial frame; stored frames stay intact
          rx_wp_ff   <= rx_cwp_ff; // R11
          rx_stat_ff <= '{words: 16'(rx_flen_ff), rsvd: '0, drop: 1'b1, err: rx_in.err};
        end
      end
      if (cfg_load && cfg_idle) begin
        rx_wp_ff  <= '0;
        rx_cwp_ff <= '0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // host receive read side: only committed frames are visible

  assign hrx_load = (hrx_cnt_ff != '0) && (!hrx_valid_ff || hrx_ready);

  always_ff @(posedge core_clk) begin
    if (rst) begin
      hrx_rp_ff    <= '0;
      hrx_cnt_ff   <= '0;
      hrx_valid_ff <= 1'b0;
      hrx_beat_ff  <= '0;
    end else begin
      if (hrx_load) begin
        hrx_beat_ff  <= store_mem[tx_sz[ST_AW-1:0] + hrx_rp_ff]; // R04
        hrx_valid_ff <= 1'b1;
        hrx_rp_ff    <= ptr_inc(hrx_rp_ff, rx_sz);
      end else if (hrx_ready) begin
        hrx_valid_ff <= 1'b0;
      end
      hrx_cnt_ff <= hrx_cnt_ff + (rx_commit ? rx_flen_ff + CW'(1) : '0)
                    - CW'(hrx_load); // R04
      if (cfg_load && cfg_idle) begin
        hrx_rp_ff <= '0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // flow control on host receive fifo fill

  assign rx_free = rx_sz - rx_used;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      fc_full_ff    <= 1'b0;
      pause_send_ff <= 1'b0;
      jam_ff        <= 1'b0;
    end else begin
      // hysteresis avoids a burst of pause frames around one threshold
      if (rx_free < FC_ON_FREE) begin
        fc_full_ff <= 1'b1;
      end else if (rx_free >= FC_OFF_FREE) begin
        fc_full_ff <= 1'b0;
      end
      pause_send_ff <= pause_req || // R08
                       (fc_auto_en && !fc_bp_mode && !fc_full_ff &&
                        (rx_free < FC_ON_FREE)); // R06 R08
      jam_ff        <= fc_auto_en && fc_bp_mode && fc_full_ff; // R07
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs

  assign htx_ready     = htx_ready_ff;
  assign hrx_valid     = hrx_valid_ff;
  assign hrx_beat      = hrx_beat_ff;
  assign tx_stat_valid = tx_stat_valid_ff;
  assign tx_stat       = tx_stat_ff;
  assign rx_stat_valid = rx_stat_valid_ff;
  assign rx_stat       = rx_stat_ff;
  assign ltx_valid     = ltx_valid_ff;
  assign ltx_beat      = ltx_beat_ff;
  assign fifo_tx_kb    = tx_kb_ff;
  assign pause_send    = pause_send_ff;
  assign jam_assert    = jam_ff;

endmodule

// File: logic/mac_buf_pkg.sv
// package: sizes, carriers and state codes of the mac packet buffering block
package mac_buf_pkg;

  localparam int unsigned WORD_W        = 32;
  localparam int unsigned BYTES_PER_WORD = 4;
  localparam int unsigned TX_BUF_BYTES  = 2048;
  localparam int unsigned RX_BUF_BYTES  = 128;
  localparam int unsigned TX_BUF_WORDS  = TX_BUF_BYTES / BYTES_PER_WORD;
  localparam int unsigned RX_BUF_WORDS  = RX_BUF_BYTES / BYTES_PER_WORD;
  localparam int unsigned TXB_AW        = $clog2(TX_BUF_WORDS);
  localparam int unsigned RXB_AW        = $clog2(RX_BUF_WORDS);

  // shared host fifo store, split between transmit and receive
  localparam int unsigned STORE_KB      = 16;
  localparam int unsigned KB_SHIFT      = 8;
  localparam int unsigned STORE_WORDS   = STORE_KB << KB_SHIFT;
  localparam int unsigned ST_AW         = $clog2(STORE_WORDS);
  localparam int unsigned CW            = ST_AW + 1;

  localparam logic [3:0]    FIFO_KB_MIN  = 4'h2;
  localparam logic [3:0]    FIFO_KB_MAX  = 4'he;
  localparam logic [3:0]    TX_KB_RST    = 4'h8;
  localparam logic [CW-1:0] STORE_SZ     = 13'h1000;
  localparam logic [CW-1:0] HTX_READY_MARGIN = 13'h002;

  // receive flow control thresholds on free words in the host receive fifo
  localparam logic [CW-1:0] FC_ON_FREE   = 13'h0200;
  localparam logic [CW-1:0] FC_OFF_FREE  = 13'h0400;

  typedef struct packed {
    logic [WORD_W-1:0] data;
    logic              last;
  } beat_t;

  typedef struct packed {
    logic  err;
    beat_t b;
  } rx_beat_t;

  typedef struct packed {
    logic [15:0] words;
    logic [13:0] rsvd;
    logic        drop;
    logic        err;
  } pkt_stat_t;

  typedef enum logic [1:0] {
    TX_IDLE = 2'b00,
    TX_FILL = 2'b01,
    TX_SEND = 2'b10
  } tx_state_t;

  typedef enum logic {
    RX_MOVE = 1'b0,
    RX_DROP = 1'b1
  } rx_state_t;

endpackage

// File: bench/mac_buf_checker.sv
// port checker for the mac packet buffering block
module mac_buf_checker import mac_buf_pkg::*; (
  // clock and reset
  input wire logic       core_clk,
  input wire logic       rst,
  // host side
  input wire logic       htx_valid,
  input wire beat_t      htx_beat,
  input wire logic       htx_ready,
  input wire logic       hrx_valid,
  input wire beat_t      hrx_beat,
  input wire logic       hrx_ready,
  // status and sizing
  input wire logic       tx_stat_valid,
  input wire pkt_stat_t  tx_stat,
  input wire logic       rx_stat_valid,
  input wire pkt_stat_t  rx_stat,
  input wire logic [3:0] fifo_tx_kb,
  // line side
  input wire logic       ltx_valid,
  input wire beat_t      ltx_beat,
  input wire logic       ltx_ready,
  input wire logic       lrx_valid,
  input wire beat_t      lrx_beat,
  input wire logic       lrx_err,
  // flow control
  input wire logic       pause_req,
  input wire logic       pause_send
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (rst);

  logic [7:0] pend_ff;
  // whole frames waiting for the line; oversize ones leave through a drop status
  always_ff @(posedge core_clk) begin
    if (rst)
      pend_ff <= 8'h00;
    else
      pend_ff <= pend_ff + 8'(htx_valid && htx_ready && htx_beat.last)
                 - 8'(ltx_valid && ltx_ready && ltx_beat.last)
                 - 8'(tx_stat_valid && tx_stat.drop);
  end

  sequence s_bad_end;
    lrx_valid && lrx_beat.last && lrx_err;
  endsequence
  sequence s_drop_stat;
    rx_stat_valid && rx_stat.drop && rx_stat.err;
  endsequence

  ////////////////////////////////////////////////////////////////////////////////
  ltx_hold_a: assert property (
    ltx_valid && !ltx_ready |=> ltx_valid && $stable(ltx_beat))
    else $error("line word changed before taken");
  hrx_hold_a: assert property (
    hrx_valid && !hrx_ready |=> hrx_valid && $stable(hrx_beat))
    else $error("host word changed before taken");
  pause_req_a: assert property (pause_req |=> pause_send)
    else $error("pause request gave no pause pulse");
  tx_pulse_a: assert property (not (tx_stat_valid ##1 tx_stat_valid))
    else $error("transmit status longer than one cycle");
  rx_pulse_a: assert property (rx_stat_valid |=> !rx_stat_valid)
    else $error("receive status longer than one cycle");
  kb_range_a: assert property (
    fifo_tx_kb >= FIFO_KB_MIN && fifo_tx_kb <= FIFO_KB_MAX)
    else $error("transmit fifo size out of range");
  bad_frame_a: assert property (s_bad_end |-> ##[1:8] s_drop_stat)
    else $error("errored frame not reported dropped");
  whole_frame_a: assert property ($rose(ltx_valid) |-> pend_ff != 8'h00)
    else $error("line send began before frame complete");
endmodule

bind mac_packet_buffering mac_buf_checker u_chk (.*);

// File: bench/mac_line_model.sv
// line side mac model: sinks transmit words, sources receive frames
module mac_line_model import mac_buf_pkg::*; (
  // clock and reset
  input  wire logic  core_clk,
  input  wire logic  rst,
  // line transmit from the block
  input  wire logic  ltx_valid,
  input  wire beat_t ltx_beat,
  output logic       ltx_ready,
  input  wire logic  slow,
  // line receive into the block
  output logic       lrx_valid,
  output beat_t      lrx_beat,
  output logic       lrx_err
);
  timeunit 1ns;
  timeprecision 100ps;
  beat_t      got[$];
  logic [1:0] ph_ff;

  // slow mode takes one word in four so the block must hold its offer
  assign ltx_ready = !slow || ph_ff == 2'h3;
  always @(posedge core_clk) begin
    ph_ff <= rst ? 2'h0 : ph_ff + 2'h1;
    if (!rst && ltx_valid && ltx_ready)
      got.push_back(ltx_beat);
  end

  initial begin
    lrx_valid = 1'b0;
    lrx_beat  = '0;
    lrx_err   = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // frame words carry the tag and their index; error flag rides on the last word
  task automatic send(input int n, input logic err, input logic [7:0] tag);
    for (int i = 0; i < n; i++) begin
      @(posedge core_clk);
      #1;
      lrx_valid = 1'b1;
      lrx_beat  = '{data: {tag, 24'(i)}, last: i == n - 1};
      lrx_err   = err && i == n - 1;
    end
    @(posedge core_clk);
    #1;
    lrx_valid = 1'b0;
    lrx_beat  = ~lrx_beat;
    lrx_err   = 1'b0;
  endtask
endmodule

// File: bench/test_mac_packet_buffering.sv
// self-checking bench for the mac packet buffering block
module test_mac_packet_buffering import mac_buf_pkg::*; ;
  timeunit 1ns;
  timeprecision 100ps;
  logic       core_clk, rst, htx_valid, htx_ready, hrx_valid, hrx_ready, slow;
  logic       tx_stat_valid, rx_stat_valid, ltx_valid, ltx_ready, lrx_valid, lrx_err;
  logic       cfg_load, fc_auto_en, fc_bp_mode, pause_req, pause_send, jam_assert;
  logic [3:0] cfg_tx_kb, fifo_tx_kb;
  beat_t      htx_beat, hrx_beat, ltx_beat, lrx_beat;
  pkt_stat_t  tx_stat, rx_stat;
  int         bad_count, num_checks, n_pause, n_full, words;

  mac_packet_buffering u_dut (.*);
  mac_line_model       u_mac (.*);

  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end

  always @(posedge core_clk) begin
    if (!rst && pause_send === 1'b1)
      n_pause++;
    if (!rst && rx_stat_valid === 1'b1 && rx_stat[1:0] === 2'b10)
      n_full++;
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic check_val(input logic [32:0] got, input logic [32:0] exp);
    num_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic report_and_stop;
    if (bad_count == 0 && num_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task automatic step(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask

  function automatic logic pick(input int k);
    case (k)
      0: return htx_ready;
      1: return tx_stat_valid;
      2: return rx_stat_valid;
      3: return hrx_valid;
      default: return jam_assert;
    endcase
  endfunction

  task automatic wait_for(input int k, input int lim);
    for (int i = 0; i < lim; i++) begin
      if (pick(k) === 1'b1)
        return;
      step(1);
    end
    bad_count++;
    $display("unexpected at %0t: got %h expected %h", $time, pick(k), 1'b1);
    report_and_stop();
  endtask

  // leaves htx_valid high so frames can follow back to back
  task automatic put_frame(input int n, input logic sf);
    for (int i = 0; i < n; i++) begin
      wait_for(0, 100);
      htx_valid = 1'b1;
      htx_beat  = '{data: 32'haa000000 | 32'(i), last: i == n - 1};
      step(1);
      if (sf && i < n - 1)
        check_val(33'(ltx_valid), 33'h0);
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_cfg;
    logic [3:0] req [5] = '{4'hf, 4'h1, 4'h0, 4'h5, 4'h8};
    logic [3:0] exp [5] = '{4'he, 4'h2, 4'h2, 4'h5, 4'h8};
    check_val(33'(fifo_tx_kb), 33'h8);
    for (int i = 0; i < 5; i++) begin
      cfg_load  = 1'b1;
      cfg_tx_kb = req[i];
      step(1);
      cfg_load = 1'b0;
      step(1);
      check_val(33'(fifo_tx_kb), 33'(exp[i]));
    end
  endtask

  task automatic t_tx;
    slow = 1'b1;
    put_frame(2, 1'b1);
    put_frame(3, 1'b0);
    htx_valid = 1'b0;
    for (int f = 2; f <= 3; f++) begin
      wait_for(1, 200);
      check_val(33'(tx_stat), 33'({16'(f), 16'h0000}));
      step(1);
    end
    for (int k = 0; k < 5; k++)
      check_val(u_mac.got[k], {32'haa000000 | 32'(k < 2 ? k : k - 2), k == 1 || k == 4});
    slow = 1'b0;
    // oversize frame must be dropped whole, never reach the line
    put_frame(513, 1'b0);
    htx_valid = 1'b0;
    wait_for(1, 600);
    check_val(33'(tx_stat), 33'h0200_0003);
    check_val(33'(u_mac.got.size()), 33'h5);
  endtask

  task automatic t_rx;
    hrx_ready = 1'b0;
    u_mac.send(2, 1'b0, 8'h11);
    wait_for(2, 20);
    check_val(33'(rx_stat), 33'h0002_0000);
    step(1);
    u_mac.send(3, 1'b1, 8'h22);
    wait_for(2, 20);
    check_val(33'(rx_stat[1:0]), 33'h3);
    hrx_ready = 1'b1;
    for (int i = 0; i < 2; i++) begin
      wait_for(3, 20);
      check_val(hrx_beat, {8'h11, 24'(i), i == 1});
      step(1);
    end
    step(4);
    check_val(33'(hrx_valid), 33'h0);
  endtask

  task automatic t_flow;
    hrx_ready = 1'b0;
    pause_req = 1'b1;
    step(1);
    pause_req = 1'b0;
    check_val(33'(pause_send), 33'h1);
    step(1);
    n_pause = 0;
    n_full = 0;
    fc_auto_en = 1'b1;
    for (int f = 0; f < 50; f++)
      u_mac.send(32, 1'b0, 8'(f));
    step(4);
    check_val(33'(n_pause), 33'h1);
    fc_bp_mode = 1'b1;
    wait_for(4, 10);
    // 8 KB receive fifo holds exactly 64 frames of 32 words
    for (int f = 0; f < 20; f++)
      u_mac.send(32, 1'b0, 8'h80);
    step(4);
    check_val(33'(n_full), 33'h6);
    hrx_ready = 1'b1;
    words = 0;
    for (int i = 0; i < 3000; i++) begin
      if (hrx_valid === 1'b1)
        words++;
      step(1);
    end
    check_val(33'(words), 33'h800);
    check_val(33'(jam_assert), 33'h0);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    rst = 1'b1;
    slow = 1'b0;
    htx_valid = 1'b0;
    htx_beat = '0;
    hrx_ready = 1'b0;
    cfg_load = 1'b0;
    cfg_tx_kb = 4'h8;
    fc_auto_en = 1'b0;
    fc_bp_mode = 1'b0;
    pause_req = 1'b0;
    bad_count = 0;
    num_checks = 0;
    n_pause = 0;
    n_full = 0;
    repeat (12) @(posedge core_clk);
    #1;
    rst = 1'b0;
    step(2);
    t_cfg();
    t_tx();
    t_rx();
    t_flow();
    report_and_stop();
  end
endmodule
